// File: design/mscr_defines.vh
`ifndef MSCR_DEFINES_VH
`define MSCR_DEFINES_VH
// external data space register addresses
`define MSCR_ADDR_PEQ 16'h2000
`define MSCR_ADDR_IRQEN 16'h2002
`define MSCR_ADDR_MISC 16'h2005
// special function register addresses
`define MSCR_SFR_ERASE 8'h94
`define MSCR_SFR_PGADR 8'hb7
`define MSCR_SFR_MEEN 8'hb2
// field positions
`define MSCR_PEQ_LSB 5
`define MSCR_PEQ_MSB 7
`define MSCR_XFR_BIT 0
`define MSCR_RTC_BIT 1
`define MSCR_LOWP_BIT 1
`define MSCR_FIRLEN_BIT 4
`define MSCR_ECKDIS_BIT 5
`define MSCR_PGADR_LSB 1
`define MSCR_PGADR_MSB 7
`define MSCR_MEEN_BIT 1
// reset values
`define MSCR_PEQ_RST 3'h0
`define MSCR_IRQEN_RST 2'h0
`define MSCR_MISC_RST 3'h0
`define MSCR_ERASE_RST 8'h00
`define MSCR_PGADR_RST 7'h00
// erase patterns
`define MSCR_PAT_PAGE 8'h55
`define MSCR_PAT_MASS 8'haa
// filter lengths in filter clock cycles
`define MSCR_FIR_LONG 9'h180
`define MSCR_FIR_SHORT 9'h120
// converter result widths for each filter length
`define MSCR_ADC_LONG 5'h16
`define MSCR_ADC_SHORT 5'h15
`endif

// File: design/mscr_erase_ctl.v
`timescale 1ns/1ps
`include "mscr_defines.vh"
// decodes erase-initiate writes into one-cycle erase starts
module mscr_erase_ctl (
	input wire ref_clk_i,
	input wire reset_i,
	input wire sfr_wr_i,
	input wire [7:0] sfr_addr_i,
	input wire [7:0] sfr_wdata_i,
	output reg page_erase_start_o,
	output reg mass_erase_start_o,
	output reg [6:0] erase_page_address_o
);
	reg pg_valid_r;
	reg meen_r;
	wire erase_wr;
	assign erase_wr = sfr_wr_i && (sfr_addr_i == `MSCR_SFR_ERASE);
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pg_valid_r <= 1'b0;
			meen_r <= 1'b0;
			erase_page_address_o <= `MSCR_PGADR_RST;
			page_erase_start_o <= 1'b0;
			mass_erase_start_o <= 1'b0;
		end else begin
			page_erase_start_o <= 1'b0;
			mass_erase_start_o <= 1'b0;
			if (sfr_wr_i && sfr_addr_i == `MSCR_SFR_PGADR) begin
				erase_page_address_o <= sfr_wdata_i[`MSCR_PGADR_MSB:`MSCR_PGADR_LSB];
				pg_valid_r <= 1'b1;
			end
			if (sfr_wr_i && sfr_addr_i == `MSCR_SFR_MEEN)
				meen_r <= sfr_wdata_i[`MSCR_MEEN_BIT];
			if (erase_wr) begin
				// page address is consumed so each cycle needs a fresh one
				if (sfr_wdata_i == `MSCR_PAT_PAGE && pg_valid_r) begin
					page_erase_start_o <= 1'b1;
					pg_valid_r <= 1'b0;
				end else if (sfr_wdata_i == `MSCR_PAT_MASS && meen_r) begin
					mass_erase_start_o <= 1'b1;
					meen_r <= 1'b0;
				end
				// other values start nothing
			end
		end
	end
endmodule

// File: design/mscr_regs.v
`timescale 1ns/1ps
`include "mscr_defines.vh"
module mscr_regs (
	input wire ref_clk_i,
	input wire reset_i,
	input wire xd_wr_i,
	input wire xd_rd_i,
	input wire [15:0] xd_addr_i,
	input wire [7:0] xd_wdata_i,
	output reg [7:0] xd_rdata_o,
	input wire sfr_wr_i,
	input wire [7:0] sfr_addr_i,
	input wire [7:0] sfr_wdata_i,
	input wire transfer_busy_event_i,
	input wire one_second_tick_i,
	input wire core_ext_irq6_enable_i,
	input wire emu_clk_i,
	output wire emu_clk_o,
	output reg [2:0] power_equation_select_o,
	output reg decimation_length_select_o,
	output reg [8:0] filter_cycles_o,
	output reg [4:0] adc_result_bits_o,
	output reg flash_low_power_o,
	output reg debug_clock_disable_o,
	output wire irq6_o,
	output wire page_erase_start_o,
	output wire mass_erase_start_o,
	output wire [6:0] erase_page_address_o
);
	reg [1:0] irq_en_r;
	reg [2:0] peq_nxt;
	reg [1:0] irq_en_nxt;
	reg debug_dis_nxt;
	reg decimation_length_select_nxt;
	reg low_power_nxt;
	reg [8:0] filter_cycles_nxt;
	reg [4:0] adc_bits_nxt;
	wire wr_peq;
	wire wr_irqen;
	wire wr_misc;
	wire rd_peq;
	wire rd_irqen;
	wire rd_misc;
	wire xfr_req;
	wire tick_req;
	// one compare shared by write and read decode
	function addr_hit;
		input strobe;
		input [15:0] addr;
		input [15:0] target;
		begin
			addr_hit = strobe && (addr == target);
		end
	endfunction
	function [8:0] fir_cycles;
		input len;
		begin
			if (len) begin
				fir_cycles = `MSCR_FIR_LONG;
			end else begin
				fir_cycles = `MSCR_FIR_SHORT;
			end
		end
	endfunction
	function [4:0] adc_bits;
		input len;
		begin
			if (len) begin
				adc_bits = `MSCR_ADC_LONG;
			end else begin
				adc_bits = `MSCR_ADC_SHORT;
			end
		end
	endfunction
	function irq_gate;
		input en;
		input ev;
		begin
			irq_gate = en & ev;
		end
	endfunction
	function [7:0] peq_image;
		input [2:0] sel;
		begin
			peq_image = 8'h00;
			peq_image[`MSCR_PEQ_MSB:`MSCR_PEQ_LSB] = sel;
		end
	endfunction
	function [7:0] irqen_image;
		input [1:0] en;
		begin
			irqen_image = 8'h00;
			irqen_image[`MSCR_XFR_BIT] = en[`MSCR_XFR_BIT];
			irqen_image[`MSCR_RTC_BIT] = en[`MSCR_RTC_BIT];
		end
	endfunction
	function [7:0] misc_image;
		input dis;
		input len;
		input lowp;
		begin
			misc_image = 8'h00;
			misc_image[`MSCR_ECKDIS_BIT] = dis;
			misc_image[`MSCR_FIRLEN_BIT] = len;
			misc_image[`MSCR_LOWP_BIT] = lowp;
		end
	endfunction
	assign wr_peq = addr_hit(xd_wr_i, xd_addr_i, `MSCR_ADDR_PEQ);
	assign wr_irqen = addr_hit(xd_wr_i, xd_addr_i, `MSCR_ADDR_IRQEN);
	assign wr_misc = addr_hit(xd_wr_i, xd_addr_i, `MSCR_ADDR_MISC);
	assign rd_peq = addr_hit(xd_rd_i, xd_addr_i, `MSCR_ADDR_PEQ);
	assign rd_irqen = addr_hit(xd_rd_i, xd_addr_i, `MSCR_ADDR_IRQEN);
	assign rd_misc = addr_hit(xd_rd_i, xd_addr_i, `MSCR_ADDR_MISC);
	// next-state: hold unless the owning address is written
	always @* begin
		peq_nxt = power_equation_select_o;
		if (wr_peq) begin
			peq_nxt = xd_wdata_i[`MSCR_PEQ_MSB:`MSCR_PEQ_LSB];
		end
	end
	always @* begin
		irq_en_nxt = irq_en_r;
		if (wr_irqen) begin
			irq_en_nxt[`MSCR_XFR_BIT] = xd_wdata_i[`MSCR_XFR_BIT];
			irq_en_nxt[`MSCR_RTC_BIT] = xd_wdata_i[`MSCR_RTC_BIT];
		end
	end
	// no power-up timer here: the firmware owns the wait before disabling
	always @* begin
		debug_dis_nxt = debug_clock_disable_o;
		decimation_length_select_nxt = decimation_length_select_o;
		low_power_nxt = flash_low_power_o;
		if (wr_misc) begin
			debug_dis_nxt = xd_wdata_i[`MSCR_ECKDIS_BIT];
			decimation_length_select_nxt = xd_wdata_i[`MSCR_FIRLEN_BIT];
			low_power_nxt = xd_wdata_i[`MSCR_LOWP_BIT];
		end
	end
	// derived counts trail the length bit by one cycle
	always @* begin
		filter_cycles_nxt = fir_cycles(decimation_length_select_o);
		adc_bits_nxt = adc_bits(decimation_length_select_o);
	end
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			power_equation_select_o <= `MSCR_PEQ_RST;
		end else begin
			power_equation_select_o <= peq_nxt;
		end
	end
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_en_r <= `MSCR_IRQEN_RST;
		end else begin
			irq_en_r <= irq_en_nxt;
		end
	end
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			{debug_clock_disable_o, decimation_length_select_o, flash_low_power_o} <=
				`MSCR_MISC_RST;
		end else begin
			debug_clock_disable_o <= debug_dis_nxt;
			decimation_length_select_o <= decimation_length_select_nxt;
			flash_low_power_o <= low_power_nxt;
		end
	end
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			filter_cycles_o <= `MSCR_FIR_SHORT;
			adc_result_bits_o <= `MSCR_ADC_SHORT;
		end else begin
			filter_cycles_o <= filter_cycles_nxt;
			adc_result_bits_o <= adc_bits_nxt;
		end
	end
	// plain gate on emulator clock; integration should swap in a glitch-free cell
	assign emu_clk_o = emu_clk_i & ~debug_clock_disable_o;
	// event sources are already on this clock, so no synchroniser
	assign xfr_req = irq_gate(irq_en_r[`MSCR_XFR_BIT], transfer_busy_event_i);
	assign tick_req = irq_gate(irq_en_r[`MSCR_RTC_BIT], one_second_tick_i);
	assign irq6_o = core_ext_irq6_enable_i & (xfr_req | tick_req);
	// unmapped or idle reads return zero
	always @* begin
		xd_rdata_o = 8'h00;
		case ({rd_misc, rd_irqen, rd_peq})
		3'b001: begin
			xd_rdata_o = peq_image(power_equation_select_o);
		end
		3'b010: begin
			xd_rdata_o = irqen_image(irq_en_r);
		end
		3'b100: begin
			xd_rdata_o = misc_image(debug_clock_disable_o, decimation_length_select_o,
				flash_low_power_o);
		end
		default: begin
			xd_rdata_o = 8'h00;
		end
		endcase
	end
	mscr_erase_ctl u_erase (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.sfr_wr_i(sfr_wr_i),
		.sfr_addr_i(sfr_addr_i),
		.sfr_wdata_i(sfr_wdata_i),
		.page_erase_start_o(page_erase_start_o),
		.mass_erase_start_o(mass_erase_start_o),
		.erase_page_address_o(erase_page_address_o)
	);
endmodule

// File: bench/mscr_regs_props.sv
`timescale 1ns/1ps
module mscr_regs_props(input wire ref_clk_i, reset_i, xd_wr_i, sfr_wr_i, emu_clk_i, emu_clk_o,
	input wire transfer_busy_event_i, one_second_tick_i, core_ext_irq6_enable_i, irq6_o,
	input wire [15:0] xd_addr_i, input wire [7:0] xd_wdata_i, sfr_addr_i, sfr_wdata_i,
	input wire [2:0] power_equation_select_o, input wire [6:0] erase_page_address_o,
	input wire decimation_length_select_o, debug_clock_disable_o,
	input wire [8:0] filter_cycles_o, input wire [4:0] adc_result_bits_o,
	input wire page_erase_start_o, mass_erase_start_o);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	wire e94 = sfr_wr_i && sfr_addr_i == 8'h94;
	a_emu_clk_gate: assert property (emu_clk_o == (emu_clk_i && !debug_clock_disable_o))
		else $error("emu gate");
	a_irq_needs_both: assert property (irq6_o |-> core_ext_irq6_enable_i &&
		(transfer_busy_event_i || one_second_tick_i)) else $error("irq gate");
	a_len_follow: assert property (##1 {filter_cycles_o, adc_result_bits_o} ==
		($past(decimation_length_select_o) ? {9'h180, 5'h16} : {9'h120, 5'h15})) else $error("len");
	a_eqsel_load: assert property (xd_wr_i && xd_addr_i == 16'h2000 |=>
		power_equation_select_o == $past(xd_wdata_i[7:5])) else $error("eqsel");
	a_misc_load: assert property (xd_wr_i && xd_addr_i == 16'h2005 |=>
		{debug_clock_disable_o, decimation_length_select_o} == $past(xd_wdata_i[5:4])) else $error("misc");
	a_page_cause: assert property (page_erase_start_o |-> $past(e94 && sfr_wdata_i == 8'h55))
		else $error("page cause");
	a_other_none: assert property (e94 && sfr_wdata_i != 8'h55 && sfr_wdata_i != 8'haa |=>
		!page_erase_start_o && !mass_erase_start_o) else $error("stray erase");
	a_mass_cause: assert property (mass_erase_start_o |-> $past(e94 && sfr_wdata_i == 8'haa))
		else $error("mass cause");
	a_page_single: assert property (page_erase_start_o |=> !page_erase_start_o)
		else $error("page width");
	a_pgadr_load: assert property (sfr_wr_i && sfr_addr_i == 8'hb7 |=>
		erase_page_address_o == $past(sfr_wdata_i[7:1])) else $error("pgadr");
	c_page: cover property (page_erase_start_o);
	c_mass: cover property (mass_erase_start_o);
	c_irq: cover property (irq6_o);
endmodule

// File: bench/tb_mscr_regs.sv
`timescale 1ns/1ps
module tb_mscr_regs;
	reg c = 0, r = 1, xw = 0, xr = 0, sw = 0, tb = 0, os = 0, ce = 0, ei = 1;
	reg [15:0] xa = 16'h0000;
	reg [7:0] xd = 8'h00, sa = 8'h00, sd = 8'h00;
	wire [7:0] rd;
	wire [8:0] fc;
	wire [6:0] pa;
	wire [4:0] ab;
	wire [2:0] eq;
	wire eo, dl, lp, dd, irq, pe, me;
	integer mismatches = 0, n_checks = 0;
	mscr_regs i_mscr_regs(.ref_clk_i(c), .reset_i(r), .xd_wr_i(xw), .xd_rd_i(xr), .xd_addr_i(xa),
		.xd_wdata_i(xd), .xd_rdata_o(rd), .sfr_wr_i(sw), .sfr_addr_i(sa), .sfr_wdata_i(sd),
		.transfer_busy_event_i(tb), .one_second_tick_i(os), .core_ext_irq6_enable_i(ce),
		.emu_clk_i(ei), .emu_clk_o(eo), .power_equation_select_o(eq),
		.decimation_length_select_o(dl), .filter_cycles_o(fc), .adc_result_bits_o(ab),
		.flash_low_power_o(lp), .debug_clock_disable_o(dd), .irq6_o(irq),
		.page_erase_start_o(pe), .mass_erase_start_o(me), .erase_page_address_o(pa));
	initial forever #50 c = ~c;
	task chk(input [15:0] s, input [15:0] e, input [63:0] n);
		n_checks = n_checks + 1;
		if (s !== e) begin
			mismatches = mismatches + 1;
			$display("CHECK FAILED %0s exp %h got %h", n, e, s);
		end
	endtask
	task xwr(input [15:0] a, input [7:0] d);
		@(posedge c) #1 {xw, xa, xd} = {1'b1, a, d};
		@(posedge c) #1 xw = 0;
	endtask
	task swr(input [7:0] a, input [7:0] d);
		@(posedge c) #1 {sw, sa, sd} = {1'b1, a, d};
		@(posedge c) #1 sw = 0;
	endtask
	// read data is combinational, so sample before the closing edge
	task xrd(input [15:0] a, input [7:0] e);
		@(posedge c) #1 {xr, xa} = {1'b1, a};
		#40 chk(rd, e, "rdata");
		@(posedge c) #1 xr = 0;
	endtask
	task t_regs;
		chk({fc, ab, pe, me}, {9'h120, 5'h15, 2'b00}, "rst");
		xwr(16'h2000, 8'he0);
		xrd(16'h2000, 8'he0);
		xrd(16'h2001, 8'h00);
		chk(eq, 3'h7, "eqsel");
		xwr(16'h2005, 8'h32);
		chk({dd, dl, lp, eo}, 4'he, "misc");
		@(posedge c) #1 chk({fc, ab}, {9'h180, 5'h16}, "len");
		xrd(16'h2005, 8'h32);
		xwr(16'h2002, 8'h01);
		{tb, ce} = 2'b11;
		#1 chk(irq, 1'b1, "irq");
		ce = 0;
		#1 chk(irq, 1'b0, "irq");
		{tb, os, ce} = 3'b011;
		#1 chk(irq, 1'b0, "irq");
		$display("t_regs done");
	endtask
	task t_erase;
		swr(8'hb7, 8'h0a);
		swr(8'h94, 8'h55);
		chk({pe, pa}, 8'h85, "page");
		swr(8'h94, 8'h55);
		chk(pe, 1'b0, "stale");
		swr(8'h94, 8'h33);
		chk(pe | me, 1'b0, "other");
		swr(8'hb2, 8'h02);
		swr(8'h94, 8'haa);
		chk(me, 1'b1, "mass");
		$display("t_erase done");
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge c);
		#1 r = 0;
		t_regs;
		t_erase;
		test_done;
	end
	// tests need about thirty cycles; this leaves wide margin
	initial begin
		#20000 mismatches = mismatches + 1;
		test_done;
	end
endmodule
bind mscr_regs mscr_regs_props i_mscr_regs_props(.*);
